//--- bcg_pkg.sv
package bcg_pkg;

  // ----------------------------------------------------------------
  // Check modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BCG_MODE_LRC   = 2'h0,
    BCG_MODE_CRC16 = 2'h1,
    BCG_MODE_CCITT = 2'h2
  } bcg_mode_t;

  // ----------------------------------------------------------------
  // Widths, polynomials and reset values
  // ----------------------------------------------------------------
  localparam int          BCG_CHAR_W     = 8;
  localparam int          BCG_BCC_W      = 16;
  localparam logic [15:0] BCG_POLY_CRC16 = 16'h8005;
  localparam logic [15:0] BCG_POLY_CCITT = 16'h1021;
  localparam logic [15:0] BCG_ACC_RESET  = 16'h0000;
  localparam logic [1:0]  BCG_MODE_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Receive sequence states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BCG_ST_DATA = 3'h1,
    BCG_ST_LOW  = 3'h2,
    BCG_ST_HIGH = 3'h4
  } bcg_state_t;

endpackage

//--- bcg_crc_step.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// One character step of the block check accumulator.
// ----------------------------------------------------------------
module bcg_crc_step (
  input  wire logic [15:0] accIn,
  input  wire logic [7:0]  charIn,
  input  wire logic [1:0]  mode,
  output logic      [15:0] accOut
);

  function automatic logic [15:0] crcStep(input logic [15:0] acc, input logic [7:0] data,
                                          input logic [15:0] poly);
    logic [15:0] r;
    logic        fb;
    r = acc;
    for (int i = 0; i < 8; i++) begin
      fb = r[15] ^ data[7 - i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ poly;
      end
    end
    return r;
  endfunction

  always_comb begin
    if (mode == bcg_pkg::BCG_MODE_CRC16) begin
      accOut = crcStep(accIn, charIn, bcg_pkg::BCG_POLY_CRC16);
    end else if (mode == bcg_pkg::BCG_MODE_CCITT) begin
      accOut = crcStep(accIn, charIn, bcg_pkg::BCG_POLY_CCITT);
    end else begin
      accOut = {8'h00, accIn[7:0] ^ charIn};
    end
  end

endmodule

`default_nettype wire

//--- bcg_block_check.sv
`timescale 1ns/1ps
`default_nettype none

module bcg_block_check (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [1:0] modeSel,
  input  wire logic       txBlockStart,
  input  wire logic       txCharValid,
  input  wire logic [7:0] txChar,
  input  wire logic       rxBlockStart,
  input  wire logic       rxCharValid,
  input  wire logic [7:0] rxChar,
  input  wire logic       rxCheckValid,
  input  wire logic [7:0] rxCheckChar,
  output logic      [15:0] txBcc,
  output logic      [15:0] rxBcc,
  output logic      [1:0]  blockMode,
  output logic             rxCheckDone,
  output logic             rxBlockGood,
  output logic             rxCheckError
);

  // ----------------------------------------------------------------
  // Accumulator steps
  // ----------------------------------------------------------------
  logic [15:0]         next_txBcc;
  logic [15:0]         next_rxBcc;
  logic [7:0]          rxCheckHigh;
  logic                rxDataTake;
  logic                rxCheckLast;
  logic                rxCheckEqual;
  bcg_pkg::bcg_state_t rxState;

  bcg_crc_step uTxStep (
    .accIn  (txBcc),
    .charIn (txChar),
    .mode   (blockMode),
    .accOut (next_txBcc)
  );

  bcg_crc_step uRxStep (
    .accIn  (rxBcc),
    .charIn (rxChar),
    .mode   (blockMode),
    .accOut (next_rxBcc)
  );

  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      blockMode <= bcg_pkg::BCG_MODE_RESET;
    end else if (txBlockStart || rxBlockStart) begin
      blockMode <= modeSel;
    end
  end

  // ----------------------------------------------------------------
  // Transmit accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || txBlockStart) begin
      txBcc <= bcg_pkg::BCG_ACC_RESET;
    end else if (txCharValid) begin
      txBcc <= next_txBcc;
    end
  end

  // ----------------------------------------------------------------
  // Receive accumulator and check compare
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || rxBlockStart) begin
      rxBcc <= bcg_pkg::BCG_ACC_RESET;
    end else if (rxDataTake) begin
      rxBcc <= next_rxBcc;
    end
  end

  // ----------------------------------------------------------------
  // Check character decoding
  // ----------------------------------------------------------------
  function automatic logic isCyclic(input logic [1:0] mode);
    return (mode == bcg_pkg::BCG_MODE_CRC16) || (mode == bcg_pkg::BCG_MODE_CCITT);
  endfunction

  function automatic logic checkMatch(input logic [1:0]  mode,
                                      input logic [7:0]  high,
                                      input logic [7:0]  low,
                                      input logic [15:0] acc);
    logic equal;
    if (isCyclic(mode)) begin
      equal = ({high, low} == acc);
    end else begin
      equal = (low == acc[7:0]);
    end
    return equal;
  endfunction

  // Data characters stop counting once the first check character has been taken.
  assign rxDataTake   = rxCharValid && (rxState == bcg_pkg::BCG_ST_DATA);
  // The last check character is the only one in longitudinal mode and the low byte in cyclic mode.
  assign rxCheckLast  = rxCheckValid && ((rxState == bcg_pkg::BCG_ST_LOW) ||
                        ((rxState == bcg_pkg::BCG_ST_DATA) && !isCyclic(blockMode)));
  assign rxCheckEqual = checkMatch(blockMode, rxCheckHigh, rxCheckChar, rxBcc);

  // ----------------------------------------------------------------
  // Receive check sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || rxBlockStart) begin
      rxState <= bcg_pkg::BCG_ST_DATA;
    end else if (rxCheckValid) begin
      case (rxState)
        bcg_pkg::BCG_ST_DATA: begin
          if (isCyclic(blockMode)) begin
            rxState <= bcg_pkg::BCG_ST_LOW;
          end else begin
            rxState <= bcg_pkg::BCG_ST_HIGH;
          end
        end
        bcg_pkg::BCG_ST_LOW: begin
          rxState <= bcg_pkg::BCG_ST_HIGH;
        end
        default: begin
          rxState <= bcg_pkg::BCG_ST_HIGH;
        end
      endcase
    end
  end

  // The high byte waits here so that both halves are compared in one step.
  always_ff @(posedge clk) begin
    if (srst || rxBlockStart) begin
      rxCheckHigh <= bcg_pkg::BCG_ACC_RESET[15:8];
    end else if (rxCheckValid && (rxState == bcg_pkg::BCG_ST_DATA) && isCyclic(blockMode)) begin
      rxCheckHigh <= rxCheckChar;
    end
  end

  // ----------------------------------------------------------------
  // Receive result flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || rxBlockStart) begin
      rxCheckDone <= 1'b0;
    end else if (rxCheckLast) begin
      rxCheckDone <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || rxBlockStart) begin
      rxBlockGood <= 1'b0;
    end else if (rxCheckLast) begin
      rxBlockGood <= rxCheckEqual;
    end
  end

  // Once set, the error stays until the next block start; later check characters are ignored.
  always_ff @(posedge clk) begin
    if (srst || rxBlockStart) begin
      rxCheckError <= 1'b0;
    end else if (rxCheckLast) begin
      rxCheckError <= !rxCheckEqual;
    end
  end

endmodule

`default_nettype wire

//--- bcg_block_check_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bcg_block_check_assertions (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [1:0]  modeSel,
  input wire logic        txBlockStart,
  input wire logic        txCharValid,
  input wire logic [7:0]  txChar,
  input wire logic        rxBlockStart,
  input wire logic        rxCheckValid,
  input wire logic [7:0]  rxCheckChar,
  input wire logic [15:0] txBcc,
  input wire logic [15:0] rxBcc,
  input wire logic [1:0]  blockMode,
  input wire logic        rxCheckDone,
  input wire logic        rxBlockGood,
  input wire logic        rxCheckError
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_tx_clear: assert property (txBlockStart |=> txBcc == 16'h0000 && blockMode == $past(modeSel)) else $error("tx");
  a_rx_clear: assert property (rxBlockStart |=> rxBcc == 16'h0000 && !rxCheckDone && !rxCheckError) else $error("rx");
  a_lrc_step: assert property (blockMode == 2'h0 && txCharValid && !txBlockStart
    |=> txBcc == {8'h00, $past(txBcc[7:0]) ^ $past(txChar)}) else $error("lrc step");
  a_tx_hold: assert property (!txCharValid && !txBlockStart |=> $stable(txBcc)) else $error("tx hold");
  a_lrc_check: assert property (blockMode == 2'h0 && rxCheckValid && !rxCheckDone && !rxBlockStart
    |=> rxCheckDone && rxBlockGood == ($past(rxCheckChar) == $past(rxBcc[7:0]))) else $error("lrc chk");
  a_flag_pair: assert property (rxCheckDone == (rxBlockGood ^ rxCheckError)) else $error("flags");
  a_err_hold: assert property (rxCheckError && !rxBlockStart |=> rxCheckError) else $error("err hold");
  a_done_hold: assert property (rxCheckDone && !rxBlockStart |=> $stable(rxBlockGood)) else $error("done");
endmodule
bind bcg_block_check bcg_block_check_assertions i_bcg_block_check_assertions (.*);
`default_nettype wire

//--- bcg_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcg_link_model (
  input  wire logic       clk,
  input  wire logic       txCharValid,
  input  wire logic [7:0] txChar,
  input  wire logic [7:0] flip,
  output logic            rxCharValid,
  output logic      [7:0] rxChar
);
  // Echoes each sent character one cycle later, corrupted by flip; idle shows the inverse.
  always_ff @(posedge clk) begin
    rxCharValid <= txCharValid;
    rxChar      <= txCharValid ? txChar ^ flip : ~txChar;
  end
endmodule
`default_nettype wire

//--- tb_block_check_generator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_block_check_generator;
  logic clk = 0, srst = 1, txBlockStart = 0, txCharValid = 0, rxBlockStart = 0, rxCheckValid = 0;
  logic rxCharValid, rxCheckDone, rxBlockGood, rxCheckError;
  logic [1:0] modeSel = 0, blockMode;
  logic [7:0] txChar = 0, rxCheckChar = 0, flip = 0, rxChar;
  logic [15:0] txBcc, rxBcc, e;
  int n_errors = 0, cmp_count = 0, seed = 32'he9ff4151;
  localparam logic [7:0] SYNC = 8'h5a;
  bcg_block_check i_bcg_block_check (.*);
  bcg_link_model i_bcg_link_model (.*);
  always #10 clk = ~clk;
  function automatic logic [15:0] nx(input logic [1:0] m, input logic [15:0] a, input logic [7:0] c);
    nx = a ^ {8'h00, c};
    if (m == 2'h1 || m == 2'h2) begin
      nx = a;
      for (int i = 7; i >= 0; i--) begin
        nx = {nx[14:0], 1'b0} ^ ((nx[15] ^ c[i]) ? (m == 2'h1 ? 16'h8005 : 16'h1021) : 16'h0);
      end
    end
  endfunction
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic blk(input logic [1:0] m, input int n, input logic bad);
    logic [15:0] r;
    logic [7:0]  q[$];
    r = 16'h0000;
    modeSel = m;
    txChar = SYNC;
    txCharValid = 1;
    repeat (2) tick;
    txCharValid = 0;
    txBlockStart = 1;
    rxBlockStart = 1;
    e = 0;
    tick;
    txBlockStart = 0;
    rxBlockStart = 0;
    chk({14'h0, blockMode}, {14'h0, m});
    chk(txBcc | rxBcc, 16'h0000);
    chk({13'h0, rxCheckDone, rxBlockGood, rxCheckError}, 16'h0000);
    for (int i = 0; i < n; i++) begin
      txChar = 8'($random(seed));
      flip = (bad && i == 1) ? 8'h10 : 8'h00;
      txCharValid = 1;
      e = nx(m, e, txChar);
      q.push_back(txChar ^ flip);
      tick;
    end
    txCharValid = 0;
    flip = 0;
    foreach (q[k]) begin
      r = nx(m, r, q[k]);
    end
    repeat (2) tick;
    chk(txBcc, e);
    chk(rxBcc, r);
    rxCheckValid = 1;
    rxCheckChar = (m == 2'h1 || m == 2'h2) ? e[15:8] : e[7:0];
    if (m == 2'h1 || m == 2'h2) begin
      tick;
      rxCheckChar = e[7:0];
    end
    tick;
    rxCheckValid = 0;
    tick;
    chk({13'h0, rxCheckDone, rxBlockGood, rxCheckError}, {13'h0, 1'b1, !bad, bad});
    rxCheckValid = 1;
    rxCheckChar = ~rxCheckChar;
    tick;
    rxCheckValid = 0;
    repeat (2) tick;
    chk({13'h0, rxCheckDone, rxBlockGood, rxCheckError}, {13'h0, 1'b1, !bad, bad});
    $display("block mode %0d bad %0d done", m, bad);
  endtask
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 0;
    for (int m = 0; m < 4; m++) begin
      blk(m[1:0], 5, 1'b0);
      blk(m[1:0], 3, 1'b1);
    end
    test_done;
  end
endmodule
`default_nettype wire
